// ===== idc_core_model.sv
// Processor-side model: configuration writes and idle instructions.
// Assumes the bench calls its tasks and drives the interrupt lines itself.
`timescale 1ns/100ps
module idc_core_model (
  input  wire        ref_clk,
  output reg         idle_exec,
  output reg         cfg_wr,
  output reg  [15:0] cfg_wdata
);
  initial begin
    idle_exec = 1'b0;
    cfg_wr = 1'b0;
    cfg_wdata = 16'h0000;
  end
  // Data flips once the strobe drops, so a stale word never passes for a live one
  task wr(input [15:0] d);
    @(negedge ref_clk);
    cfg_wr = 1'b1;
    cfg_wdata = d;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
    cfg_wdata = ~d;
  endtask
  task idle;
    @(negedge ref_clk);
    idle_exec = 1'b1;
    @(negedge ref_clk);
    idle_exec = 1'b0;
  endtask
endmodule // idc_core_model

// ===== idc_ctrl_monitor.sv
// Port checker for the idle domain controller.
// Assumes binding into the controller; its input names match the controller ports.
`timescale 1ns/100ps
module idc_ctrl_monitor (
  input wire        ref_clk,
  input wire        rst_n,
  input wire        rst,
  input wire        idle_exec,
  input wire        cfg_wr,
  input wire        global_irq_mask,
  input wire        nmi_req,
  input wire [15:0] idle_config,
  input wire [15:0] idle_status,
  input wire        processor_idle_r,
  input wire        clk_run_r,
  input wire        bus_error_irq,
  input wire        resume_r,
  input wire        service_r
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || !rst_n);
  property p_rsvd; idle_config[15:6] == 10'h000 && idle_status[15:6] == 10'h000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  // A write just before idle is still in flight, so such idles are not judged
  property p_copy; idle_exec && !idle_status[0] && !$past(cfg_wr) |->
    ##2 idle_status[5:0] == $past(idle_config[5:0], 2); endproperty
  a_copy: assert property (p_copy) else $error("status not copied");
  property p_dom; processor_idle_r == idle_status[0]; endproperty
  a_dom: assert property (p_dom) else $error("processor control wrong");
  property p_clk; clk_run_r == !idle_status[4]; endproperty
  a_clk: assert property (p_clk) else $error("clock run wrong");
  property p_berr; idle_exec && !idle_status[0] && !$past(cfg_wr) |=>
    bus_error_irq == ($past(idle_config[4]) && $past(idle_config[2:0]) != 3'h7); endproperty
  a_berr: assert property (p_berr) else $error("bus error wrong");
  property p_nmi; $rose(nmi_req) && idle_status[0] |-> ##2 resume_r && service_r; endproperty
  a_nmi: assert property (p_nmi) else $error("nonmaskable wake lost");
  // The mask is judged on the edge that launched the service pulse
  property p_svc; resume_r |-> service_r == ($past(nmi_req, 2) || !$past(global_irq_mask));
    endproperty
  a_svc: assert property (p_svc) else $error("service choice wrong");
  property p_wake; resume_r |=> idle_status[5:0] == ($past(idle_status[5:0]) & 6'h2e)
    && $stable(idle_config); endproperty
  a_wake: assert property (p_wake) else $error("wake bits wrong");
  property p_react; resume_r |=> !processor_idle_r && clk_run_r; endproperty
  a_react: assert property (p_react) else $error("woken domains still idle");
endmodule // idc_ctrl_monitor
bind idc_idle_domain_controller idc_ctrl_monitor i_mon (.*);

// ===== idc_defines.vh
// Constants for the idle domain controller: register layout, reset values, timing.
// Assumes inclusion by bare name from the design files of this folder.
`ifndef IDC_DEFINES_VH
`define IDC_DEFINES_VH

// ----------------------------------------------------------------------
// Register word and field layout
// ----------------------------------------------------------------------
`define IDC_REG_W          16
`define IDC_FLD_W          6
`define IDC_BIT_PROC       0
`define IDC_BIT_XFER       1
`define IDC_BIT_ICACHE     2
`define IDC_BIT_PERIPHERAL_DOMAIN     3
`define IDC_BIT_CLOCK_GEN_DOMAIN     4
`define IDC_BIT_EXT_MEM_INTERFACE       5
`define IDC_CFG_RESET      6'h00
`define IDC_STAT_RESET     6'h00
`define IDC_RSVD_READ      10'h000

// ----------------------------------------------------------------------
// Interrupt word widths and system timing
// ----------------------------------------------------------------------
`define IDC_IRQ_W          16
`define IDC_NUM_PERIPHERAL_DOMAIN     8
`define IDC_CLK_PERIOD_NS  10
`define IDC_CLK_STOP_NS    10
`define IDC_CLK_STOP_CYC   ((`IDC_CLK_STOP_NS + `IDC_CLK_PERIOD_NS - 1) / `IDC_CLK_PERIOD_NS)

`endif

// ===== idc_idle_domain_controller.v
// Idle domain controller: pending configuration, idle status and domain idle controls.
// Assumes a processor that pulses idle_exec for one ref_clk cycle per idle instruction,
// drives the register port synchronously, and dispatches interrupts itself.
`timescale 1ns/100ps
`include "idc_defines.vh"

// Functional notes
// - Idle instruction copies config into status
// - Hardware reset forces every domain active
// - Reset clears config and status registers
// - Processor idle blocks writes and idle
// - Wake clears clock and processor status
// - Cleared status bits reactivate those domains
// - Wake only by enabled, nonmaskable or reset
// - Waking maskable request sets its flag
// - Mask clear: service and resume in the same cycle
// - Mask set: resume, defer service
// - Nonmaskable wake: service and resume in the same cycle
// - Clock generator idle stops internal clocks
// - Six config bits, upper bits read zero
// - One means idle at next instruction
// - Peripheral idles only with own enable
// - Bad clock idle config raises bus error
// - Status read-only, same layout, one idle
// - Wake touches only clock and processor
module idc_idle_domain_controller (
  input  wire                        ref_clk,
  input  wire                        rst_n,
  input  wire                        rst,
  input  wire                        idle_exec,
  input  wire                        cfg_wr,
  input  wire [`IDC_REG_W-1:0]       cfg_wdata,
  input  wire                        global_irq_mask,
  input  wire [`IDC_IRQ_W-1:0]       irq_req_lo,
  input  wire [`IDC_IRQ_W-1:0]       irq_req_hi,
  input  wire [`IDC_IRQ_W-1:0]       irq_enable_lo,
  input  wire [`IDC_IRQ_W-1:0]       irq_enable_hi,
  input  wire                        nmi_req,
  input  wire [`IDC_NUM_PERIPHERAL_DOMAIN-1:0]  peripheral_domain_idle_en,
  output reg  [`IDC_REG_W-1:0]       idle_config,
  output reg  [`IDC_REG_W-1:0]       idle_status,
  output reg                         processor_idle_r,
  output reg                         xfer_ctrl_idle_r,
  output reg                         icache_idle_r,
  output reg                         ext_mem_if_idle_r,
  output reg                         clock_gen_idle_r,
  output reg                         clk_run_r,
  output wire [`IDC_NUM_PERIPHERAL_DOMAIN-1:0]  peripheral_domain_idle_r,
  output reg                         bus_error_irq,
  output reg                         device_reset_r,
  output reg  [`IDC_IRQ_W-1:0]       irq_flag_set_lo,
  output reg  [`IDC_IRQ_W-1:0]       irq_flag_set_hi,
  output reg                         resume_r,
  output reg                         service_r
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  reg  [`IDC_FLD_W-1:0] cfg_r;
  reg  [`IDC_FLD_W-1:0] stat_r;
  reg  [`IDC_FLD_W-1:0] stat_nxt;
  reg                   rst_n_d_r;

  wire                  wake;
  wire                  wake_nmi;
  wire [`IDC_IRQ_W-1:0] flag_lo;
  wire [`IDC_IRQ_W-1:0] flag_hi;
  wire                  proc_halted;
  wire                  hw_reset;

  // Pin reset and the system reset both count as a device reset
  assign hw_reset    = rst | ~rst_n;
  assign proc_halted = stat_r[`IDC_BIT_PROC];

  // Upper reserved bits always zero
  function [`IDC_REG_W-1:0] idc_word;
    input [`IDC_FLD_W-1:0] f;
    begin
      idc_word = {`IDC_RSVD_READ, f};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Wake detection and peripheral gating
  // ----------------------------------------------------------------------
  idc_wake_detect u_wake (
    .ref_clk       (ref_clk),
    .rst           (hw_reset),
    .irq_req_lo    (irq_req_lo),
    .irq_req_hi    (irq_req_hi),
    .irq_enable_lo (irq_enable_lo),
    .irq_enable_hi (irq_enable_hi),
    .nmi_req       (nmi_req),
    .wake_r        (wake),
    .wake_nmi_r    (wake_nmi),
    .set_flag_lo_r (flag_lo),
    .set_flag_hi_r (flag_hi)
  );

  idc_peripheral_domain_gate u_peripheral_domain (
    .ref_clk          (ref_clk),
    .rst              (hw_reset),
    .peripheral_domain_idle_stat (stat_r[`IDC_BIT_PERIPHERAL_DOMAIN]),
    .peripheral_domain_idle_en   (peripheral_domain_idle_en),
    .peripheral_domain_idle_r    (peripheral_domain_idle_r)
  );

  // ----------------------------------------------------------------------
  // Status next value
  // ----------------------------------------------------------------------
  always @* begin
    stat_nxt = stat_r;
    if (wake && proc_halted) begin
      // Wake clears only two bits; the others keep their value
      stat_nxt[`IDC_BIT_PROC]   = 1'b0;
      stat_nxt[`IDC_BIT_CLOCK_GEN_DOMAIN] = 1'b0;
    end else if (idle_exec && !proc_halted) begin
      stat_nxt = cfg_r;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always @(posedge ref_clk or posedge hw_reset) begin
    if (hw_reset) begin
      cfg_r  <= `IDC_CFG_RESET;
      stat_r <= `IDC_STAT_RESET;
    end else begin
      // A halted core cannot write; a wake leaves the config untouched
      if (cfg_wr && !proc_halted) begin
        cfg_r <= cfg_wdata[`IDC_FLD_W-1:0];
      end
      stat_r <= stat_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------------
  always @(posedge ref_clk or posedge hw_reset) begin
    if (hw_reset) begin
      idle_config       <= 16'h0000;
      idle_status       <= 16'h0000;
      processor_idle_r  <= 1'b0;
      xfer_ctrl_idle_r  <= 1'b0;
      icache_idle_r     <= 1'b0;
      ext_mem_if_idle_r <= 1'b0;
      clock_gen_idle_r  <= 1'b0;
      clk_run_r         <= 1'b1;
      bus_error_irq     <= 1'b0;
      irq_flag_set_lo   <= 16'h0000;
      irq_flag_set_hi   <= 16'h0000;
      resume_r          <= 1'b0;
      service_r         <= 1'b0;
    end else begin
      idle_config       <= idc_word(cfg_r);
      idle_status       <= idc_word(stat_r);
      processor_idle_r  <= stat_r[`IDC_BIT_PROC];
      xfer_ctrl_idle_r  <= stat_r[`IDC_BIT_XFER];
      icache_idle_r     <= stat_r[`IDC_BIT_ICACHE];
      ext_mem_if_idle_r <= stat_r[`IDC_BIT_EXT_MEM_INTERFACE];
      clock_gen_idle_r  <= stat_r[`IDC_BIT_CLOCK_GEN_DOMAIN];
      // All internal clocks, the processor's included, stop together
      clk_run_r         <= ~stat_r[`IDC_BIT_CLOCK_GEN_DOMAIN];
      // Checked at the idle instruction, while the core can still take it
      bus_error_irq     <= idle_exec && !proc_halted && cfg_r[`IDC_BIT_CLOCK_GEN_DOMAIN] &&
                           !(cfg_r[`IDC_BIT_PROC] && cfg_r[`IDC_BIT_XFER] &&
                             cfg_r[`IDC_BIT_ICACHE]);
      irq_flag_set_lo   <= (wake && proc_halted) ? flag_lo : 16'h0000;
      irq_flag_set_hi   <= (wake && proc_halted) ? flag_hi : 16'h0000;
      resume_r          <= wake && proc_halted;
      // Service is deferred by the mask, but never for the nonmaskable one
      service_r         <= wake && proc_halted &&
                           (wake_nmi || !global_irq_mask);
    end
  end

  // Device reset indication: high during and one cycle after the pin reset or the system reset
  always @(posedge ref_clk or posedge hw_reset) begin
    if (hw_reset) begin
      rst_n_d_r      <= 1'b0;
      device_reset_r <= 1'b1;
    end else begin
      rst_n_d_r      <= 1'b1;
      device_reset_r <= ~rst_n_d_r;
    end
  end

endmodule // idc_idle_domain_controller

// ===== idc_peripheral_domain_gate.v
// Per-peripheral idle gating from the peripheral domain status and enable bits.
// Assumes enables are static software settings synchronous to ref_clk.
`timescale 1ns/100ps
`include "idc_defines.vh"

module idc_peripheral_domain_gate (
  input  wire                        ref_clk,
  input  wire                        rst,
  input  wire                        peripheral_domain_idle_stat,
  input  wire [`IDC_NUM_PERIPHERAL_DOMAIN-1:0]  peripheral_domain_idle_en,
  output reg  [`IDC_NUM_PERIPHERAL_DOMAIN-1:0]  peripheral_domain_idle_r
);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      peripheral_domain_idle_r <= 8'h00;
    end else if (peripheral_domain_idle_stat) begin
      peripheral_domain_idle_r <= peripheral_domain_idle_en;
    end else begin
      peripheral_domain_idle_r <= 8'h00;
    end
  end

endmodule // idc_peripheral_domain_gate

// ===== idc_wake_detect.v
// Wake-request detector: decides whether a pending interrupt may wake a halted core.
// Assumes request and enable inputs are synchronous to ref_clk.
`timescale 1ns/100ps
`include "idc_defines.vh"

module idc_wake_detect (
  input  wire                    ref_clk,
  input  wire                    rst,
  input  wire [`IDC_IRQ_W-1:0]   irq_req_lo,
  input  wire [`IDC_IRQ_W-1:0]   irq_req_hi,
  input  wire [`IDC_IRQ_W-1:0]   irq_enable_lo,
  input  wire [`IDC_IRQ_W-1:0]   irq_enable_hi,
  input  wire                    nmi_req,
  output reg                     wake_r,
  output reg                     wake_nmi_r,
  output reg  [`IDC_IRQ_W-1:0]   set_flag_lo_r,
  output reg  [`IDC_IRQ_W-1:0]   set_flag_hi_r
);

  wire                  maskable_hit;
  wire [`IDC_IRQ_W-1:0] hit_lo;
  wire [`IDC_IRQ_W-1:0] hit_hi;

  // Only enabled maskable sources, or the nonmaskable one, count as wake
  assign hit_lo       = irq_req_lo & irq_enable_lo;
  assign hit_hi       = irq_req_hi & irq_enable_hi;
  assign maskable_hit = |{hit_lo, hit_hi};

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wake_r        <= 1'b0;
      wake_nmi_r    <= 1'b0;
      set_flag_lo_r <= 16'h0000;
      set_flag_hi_r <= 16'h0000;
    end else begin
      wake_r        <= maskable_hit | nmi_req;
      wake_nmi_r    <= nmi_req;
      set_flag_lo_r <= hit_lo;
      set_flag_hi_r <= hit_hi;
    end
  end

endmodule // idc_wake_detect

// ===== tb_idle_domain_controller.sv
// Self-checking bench for the idle domain controller.
// Assumes the core model issues writes and idles; the bench drives the interrupts.
`timescale 1ns/100ps
module tb_idle_domain_controller;
  reg         ref_clk, rst_n, rst, global_irq_mask, nmi_req;
  reg  [15:0] irq_req_lo, irq_enable_lo, irq_req_hi, irq_enable_hi, berr_base;
  reg  [15:0] berr_cnt = 16'h0000;
  reg  [15:0] flag_lo_or = 16'h0000;
  reg  [15:0] flag_hi_or = 16'h0000;
  reg  [7:0]  peripheral_domain_idle_en;
  wire        idle_exec, cfg_wr, clk_run_r, bus_error_irq, device_reset_r;
  wire        processor_idle_r, xfer_ctrl_idle_r, icache_idle_r, ext_mem_if_idle_r;
  wire        clock_gen_idle_r;
  wire [15:0] cfg_wdata, idle_config, idle_status, irq_flag_set_lo, irq_flag_set_hi;
  wire [15:0] dom_idle;
  wire [7:0]  peripheral_domain_idle_r;
  integer     failures, n_checks, i;
  idc_core_model i_core (.ref_clk(ref_clk), .idle_exec(idle_exec), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata));
  idc_idle_domain_controller i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .rst(rst),
    .idle_exec(idle_exec), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .global_irq_mask(global_irq_mask), .irq_req_lo(irq_req_lo), .irq_req_hi(irq_req_hi),
    .irq_enable_lo(irq_enable_lo), .irq_enable_hi(irq_enable_hi), .nmi_req(nmi_req),
    .peripheral_domain_idle_en(peripheral_domain_idle_en), .idle_config(idle_config), .idle_status(idle_status),
    .processor_idle_r(processor_idle_r), .xfer_ctrl_idle_r(xfer_ctrl_idle_r),
    .icache_idle_r(icache_idle_r), .ext_mem_if_idle_r(ext_mem_if_idle_r),
    .clock_gen_idle_r(clock_gen_idle_r), .clk_run_r(clk_run_r), .peripheral_domain_idle_r(peripheral_domain_idle_r),
    .bus_error_irq(bus_error_irq), .device_reset_r(device_reset_r),
    .irq_flag_set_lo(irq_flag_set_lo), .irq_flag_set_hi(irq_flag_set_hi), .resume_r(),
    .service_r());
  // Peripheral_domain bit left out: its idling is judged on peripheral_domain_idle_r
  assign dom_idle = {10'h000, ext_mem_if_idle_r, clock_gen_idle_r, 1'b0, icache_idle_r,
    xfer_ctrl_idle_r, processor_idle_r};
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Pulse counter and sticky flags: an unknown on the output poisons them and fails a check
  always @(posedge ref_clk) begin
    berr_cnt   <= berr_cnt + {15'h0000, bus_error_irq};
    flag_lo_or <= flag_lo_or | irq_flag_set_lo;
    flag_hi_or <= flag_hi_or | irq_flag_set_hi;
  end
  task chk(input [63:0] nm, input [15:0] exp, input [15:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[ERR] %0s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge ref_clk);
  endtask
  task go(input [15:0] c);
    i_core.wr(c);
    cyc(2);
    i_core.idle;
    cyc(3);
  endtask
  // Request held five cycles: the wake takes two edges, the rest covers the output stage
  task wake(input n, input [15:0] en_lo, input [15:0] en_hi);
    @(negedge ref_clk);
    nmi_req = n;
    irq_req_lo = {15'h0000, !n};
    irq_req_hi = {!n, 15'h0000};
    irq_enable_lo = en_lo;
    irq_enable_hi = en_hi;
    cyc(5);
    nmi_req = 1'b0;
    irq_req_lo = 16'h0000;
    irq_req_hi = 16'h0000;
    cyc(2);
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // The tests need well under a thousand cycles; ten thousand means a hang
  initial begin
    #100000;
    failures = failures + 1;
    wrap_up;
  end
  initial begin
    {rst, rst_n, global_irq_mask, nmi_req} = 4'b1100;
    irq_req_lo = 16'h0000;
    irq_req_hi = 16'h0000;
    irq_enable_lo = 16'h0000;
    irq_enable_hi = 16'h0000;
    berr_base = 16'h0000;
    peripheral_domain_idle_en = 8'ha5;
    failures = 0;
    n_checks = 0;
    cyc(8);
    chk("clk", 16'h0001, clk_run_r);
    chk("drst", 16'h0001, device_reset_r);
    rst = 1'b0;
    cyc(2);
    chk("drst", 16'h0000, device_reset_r);
    chk("cfg", 16'h0000, idle_config);
    chk("stat", 16'h0000, idle_status);
    $display("test reset done");
    for (i = 0; i < 6; i = i + 1) begin
      berr_base = berr_cnt;
      go(16'hffc0 | (16'h0001 << i));
      chk("cfg", 16'h0001 << i, idle_config);
      chk("stat", 16'h0001 << i, idle_status);
      chk("dom", (16'h0001 << i) & 16'h0037, dom_idle);
      chk("berr", {15'h0000, i == 4}, berr_cnt - berr_base);
      chk("clk", i != 4, clk_run_r);
      chk("per", (i == 3) ? 16'h00a5 : 16'h0000, peripheral_domain_idle_r);
      if (i == 0) begin
        i_core.wr(16'h003f);
        i_core.idle;
        cyc(2);
        chk("halt", 16'h0001, idle_status);
        chk("haltcfg", 16'h0001, idle_config);
        wake(1'b0, 16'h0001, 16'h0000);
        chk("wake", 16'h0000, idle_status);
        chk("flaglo", 16'h0001, flag_lo_or);
        chk("flaghi", 16'h0000, flag_hi_or);
      end
    end
    $display("test single domains done");
    global_irq_mask = 1'b1;
    go(16'h003f);
    wake(1'b0, 16'h0000, 16'h0000);
    chk("nowake", 16'h003f, idle_status);
    chk("clk", 16'h0000, clk_run_r);
    wake(1'b0, 16'h0000, 16'h8000);
    chk("masked", 16'h002e, idle_status);
    chk("dom", 16'h0026, dom_idle);
    chk("per", 16'h00a5, peripheral_domain_idle_r);
    chk("clk", 16'h0001, clk_run_r);
    chk("flaghi", 16'h8000, flag_hi_or);
    chk("cfg", 16'h003f, idle_config);
    $display("test maskable wake done");
    go(16'h0017);
    wake(1'b1, 16'h0000, 16'h0000);
    chk("nmi", 16'h0006, idle_status);
    chk("nmiflag", 16'h0001, flag_lo_or);
    $display("test nonmaskable wake done");
    go(16'h003f);
    rst_n = 1'b0;
    cyc(1);
    chk("pinrst", 16'h0000, idle_status | idle_config);
    chk("pindom", 16'h0000, dom_idle | peripheral_domain_idle_r);
    chk("clk", 16'h0001, clk_run_r);
    chk("drst", 16'h0001, device_reset_r);
    rst_n = 1'b1;
    cyc(2);
    chk("drst", 16'h0000, device_reset_r);
    $display("test pin reset done");
    wrap_up;
  end
endmodule // tb_idle_domain_controller
